// ### hw/i2cmp_regs.vh
// constants of the two-wire memory slave port
// assumes inclusion by the port and its fifo
`ifndef I2CMP_REGS_VH
`define I2CMP_REGS_VH
// device type code; the value is arbitrary
`define I2CMP_TYPE_CODE 4'h5
`define I2CMP_ADDR_W 13
`define I2CMP_MEM_DEPTH 8192
`define I2CMP_ADDR_LAST 13'h1fff
`define I2CMP_ADDR_ZERO 13'h0000
`define I2CMP_FIFO_DEPTH 32
`define I2CMP_FIFO_AW 5
`define I2CMP_BIT_LAST 3'h7
`define I2CMP_RW_READ 1'b1
`endif

// ### hw/i2cmp_slave.v
// two-wire serial slave port with 8192-byte memory and write fifo
// assumes scl and sda arrive asynchronously; open-drain resolved outside
`timescale 1ns/1ps
`default_nettype none
`include "i2cmp_regs.vh"

module i2cmp_fifo #(
    parameter WIDTH = 21,
    parameter DEPTH = 32,
    parameter AW = 5
)
(
    input wire clk_i,
    input wire reset_n_i,
    input wire ce_i,
    input wire in_valid_i,
    output wire in_ready_o,
    input wire [WIDTH-1:0] in_data_i,
    output wire out_valid_o,
    input wire out_ready_i,
    output wire [WIDTH-1:0] out_data_o
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0] wr_ptr;
    reg [AW:0] rd_ptr;
    wire full;
    wire empty;
    assign full = (wr_ptr[AW] != rd_ptr[AW]) &&
        (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
    assign empty = (wr_ptr == rd_ptr);
    assign in_ready_o = !full;
    assign out_valid_o = !empty;
    assign out_data_o = mem[rd_ptr[AW-1:0]];
    always @(posedge clk_i)
    begin
        if (ce_i && in_valid_i && !full)
            mem[wr_ptr[AW-1:0]] <= in_data_i;
    end
    always @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            wr_ptr <= {(AW+1){1'b0}};
            rd_ptr <= {(AW+1){1'b0}};
        end
        else if (ce_i)
        begin
            if (in_valid_i && !full)
                wr_ptr <= wr_ptr + 1'b1;
            if (out_ready_i && !empty)
                rd_ptr <= rd_ptr + 1'b1;
        end
    end
endmodule

// Behaviour
// RULE1: stop aborts, returns to idle
// RULE2: start aborts, expects slave address
// RULE3: data sampled while scl high
// RULE4: ninth clock carries acknowledge
// RULE5: missing acknowledge aborts, readdressable
// RULE6: top nibble must match type code
// RULE7: bits three-one match select pins
// RULE8: bit zero one means read
// RULE9: two address bytes load 13-bit latch
// RULE10: latch increments before acknowledge
// RULE11: last location wraps to zero
// RULE12: reads start at current latch
// RULE13: no limit on bytes per operation
// RULE14: read sends byte, continues on ack
// RULE15: write receives byte, then acknowledges
// RULE16: bytes shifted msb first
// RULE17: memory write after eighth bit only
// RULE18: no busy time, always acknowledged
// RULE19: write protect blocks ack and write
// RULE20: protected write leaves counter unchanged
// RULE21: low or open protect means enabled
// RULE22: master nacks final read byte
// RULE23: top three address bits ignored
// RULE24: sample rising, drive on falling
// RULE25: random read via write then restart
// RULE26: drive sda low only when ours
module i2cmp_slave
(
    // clock, reset, enable
    input wire CLK_I,
    input wire RESET_N_I,
    input wire CE_I,
    // two-wire bus
    input wire SCL_I,
    input wire SDA_I,
    output wire SDA_O,
    output wire SDA_OE_O,
    // straps
    input wire [2:0] DEVICE_SELECT_PINS_I,
    input wire WRITE_PROTECT_I,
    // status
    output reg BUSY_O,
    output wire [12:0] ADDR_LATCH_O,
    output wire WRITE_BACKLOG_O
);
    localparam ST_IDLE = 3'd0;
    localparam ST_DEVADR = 3'd1;
    localparam ST_ADRHI = 3'd2;
    localparam ST_ADRLO = 3'd3;
    localparam ST_WDATA = 3'd4;
    localparam ST_RDATA = 3'd5;

    reg [1:0] scl_s;
    reg [1:0] sda_s;
    reg scl_d;
    reg sda_d;
    reg [2:0] state;
    reg [2:0] bit_cnt;
    reg in_ack;
    reg [7:0] shift;
    reg [7:0] tx;
    reg [12:0] addr;
    reg [4:0] addr_hi;
    reg ack_drive;
    reg data_drive;
    reg ack_ok;
    reg [7:0] mem [0:`I2CMP_MEM_DEPTH-1];
    reg [1:0] wp_s;
    wire [2:0] sel_sync;
    genvar gi;

    // fifo between the serial side and the array write port
    wire f_ready;
    wire f_valid;
    wire [20:0] f_data;
    reg f_push;
    reg [20:0] f_in;

    i2cmp_fifo #(
        .WIDTH(21),
        .DEPTH(`I2CMP_FIFO_DEPTH),
        .AW(`I2CMP_FIFO_AW)
    ) u_fifo (
        .clk_i(CLK_I),
        .reset_n_i(RESET_N_I),
        .ce_i(CE_I),
        .in_valid_i(f_push),
        .in_ready_o(f_ready),
        .in_data_i(f_in),
        .out_valid_o(f_valid),
        .out_ready_i(1'b1),
        .out_data_o(f_data)
    );
    assign WRITE_BACKLOG_O = f_valid;

    wire scl_rise = scl_s[1] && !scl_d;
    wire scl_fall = !scl_s[1] && scl_d;
    // RULE2: start detection
    wire start_c = scl_s[1] && scl_d && sda_d && !sda_s[1];
    // RULE1: stop detection
    wire stop_c = scl_s[1] && scl_d && !sda_d && sda_s[1];
    wire [7:0] rx_byte = {shift[6:0], sda_s[1]};
    // slave address fields
    wire [3:0] rx_type = rx_byte[7:4];
    wire [2:0] rx_select = rx_byte[3:1];

    // RULE11: wrap at last location
    wire [12:0] addr_inc = (addr == `I2CMP_ADDR_LAST) ?
        `I2CMP_ADDR_ZERO : addr + 13'h0001;
    // RULE21: open input pulled low outside; low enables writes
    wire wp = wp_s[1];

    assign ADDR_LATCH_O = addr;
    // RULE26: drive only low, only own slots
    assign SDA_O = 1'b0;
    assign SDA_OE_O = ack_drive || (data_drive && !tx[7]);

    // RULE7: select straps, two flops per pin
    generate
        for (gi = 0; gi < 3; gi = gi + 1)
        begin : g_sel_sync
            reg [1:0] sel_ff;
            always @(posedge CLK_I or negedge RESET_N_I)
            begin
                if (!RESET_N_I)
                    sel_ff <= 2'b00;
                else if (CE_I)
                    sel_ff <= {sel_ff[0], DEVICE_SELECT_PINS_I[gi]};
            end
            assign sel_sync[gi] = sel_ff[1];
        end
    endgenerate

    // RULE21: protect strap resets to unprotected
    always @(posedge CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            wp_s <= 2'b00;
        end
        else if (CE_I)
        begin
            wp_s <= {wp_s[0], WRITE_PROTECT_I};
        end
    end

    // array write port, drained every cycle
    always @(posedge CLK_I)
    begin
        if (CE_I && f_valid)
            mem[f_data[20:8]] <= f_data[7:0];
    end

    always @(posedge CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            scl_s <= 2'b11;
            sda_s <= 2'b11;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end
        else if (CE_I)
        begin
            scl_s <= {scl_s[0], SCL_I};
            sda_s <= {sda_s[0], SDA_I};
            scl_d <= scl_s[1];
            sda_d <= sda_s[1];
        end
    end

    always @(posedge CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            state <= ST_IDLE;
            bit_cnt <= 3'h0;
            in_ack <= 1'b0;
            shift <= 8'h00;
            tx <= 8'h00;
            addr <= `I2CMP_ADDR_ZERO;
            addr_hi <= 5'h00;
            ack_drive <= 1'b0;
            data_drive <= 1'b0;
            ack_ok <= 1'b0;
            f_push <= 1'b0;
            f_in <= 21'h00_0000;
            BUSY_O <= 1'b0;
        end
        else if (CE_I)
        begin
            f_push <= 1'b0;
            BUSY_O <= (state != ST_IDLE);
            if (start_c)
            begin
                // RULE2: abort and await slave address
                state <= ST_DEVADR;
                bit_cnt <= 3'h0;
                in_ack <= 1'b0;
                ack_drive <= 1'b0;
                data_drive <= 1'b0;
            end
            else if (stop_c)
            begin
                // RULE1: abort to idle
                state <= ST_IDLE;
                in_ack <= 1'b0;
                ack_drive <= 1'b0;
                data_drive <= 1'b0;
            end
            else if (state != ST_IDLE && scl_rise)
            begin
                if (!in_ack)
                begin
                    // RULE3: sample while high; RULE16: msb first
                    shift <= rx_byte;
                    bit_cnt <= bit_cnt + 3'h1;
                    if (bit_cnt == `I2CMP_BIT_LAST)
                    begin
                        // RULE4: ninth clock follows
                        in_ack <= 1'b1;
                        ack_ok <= 1'b0;
                        case (state)
                            ST_DEVADR:
                            begin
                                // RULE6: type code; RULE7: select pins
                                // RULE18: always ready
                                ack_ok <= (rx_type == `I2CMP_TYPE_CODE) &&
                                    (rx_select == sel_sync);
                            end
                            ST_ADRHI:
                            begin
                                // RULE23: top three bits ignored
                                addr_hi <= rx_byte[4:0];
                                ack_ok <= 1'b1;
                            end
                            ST_ADRLO:
                            begin
                                // RULE9: latch 13-bit address
                                addr <= {addr_hi, rx_byte};
                                ack_ok <= 1'b1;
                            end
                            ST_WDATA:
                            begin
                                // RULE19: protect blocks ack and write
                                // RULE20: no increment when protected
                                // RULE17: write after eighth bit
                                // RULE10: increment before ack
                                if (!wp && f_ready)
                                begin
                                    f_push <= 1'b1;
                                    f_in <= {addr, rx_byte};
                                    addr <= addr_inc;
                                    ack_ok <= 1'b1;
                                end
                            end
                            ST_RDATA:
                            begin
                                // RULE10: read increments before ack
                                addr <= addr_inc;
                            end
                            default:
                            begin
                                // unused codes fall back to idle
                                state <= ST_IDLE;
                            end
                        endcase
                    end
                end
                else
                begin
                    in_ack <= 1'b0;
                    if (state == ST_RDATA)
                    begin
                        // RULE14: continue on ack, else end
                        // RULE5: nack aborts
                        if (sda_s[1])
                            state <= ST_IDLE;
                    end
                    else if (!ack_ok)
                        // RULE5: not acknowledged, abort
                        state <= ST_IDLE;
                    else if (state == ST_DEVADR)
                        // RULE8: direction bit
                        state <= (shift[0] == `I2CMP_RW_READ) ?
                            ST_RDATA : ST_ADRHI;
                    else if (state == ST_ADRHI)
                        state <= ST_ADRLO;
                    else
                        // RULE13: unlimited bytes; RULE25: restart reads
                        state <= ST_WDATA;
                end
            end
            else if (scl_fall)
            begin
                // RULE24: outgoing bits change on falling edge
                ack_drive <= 1'b0;
                data_drive <= 1'b0;
                if (in_ack && state != ST_RDATA && ack_ok)
                    // RULE15: acknowledge received byte
                    ack_drive <= 1'b1;
                else if (state == ST_RDATA && !in_ack)
                begin
                    data_drive <= 1'b1;
                    if (bit_cnt == 3'h0)
                        // RULE12: read from current latch
                        tx <= mem[addr];
                    else
                        tx <= {tx[6:0], 1'b0};
                end
                else if (in_ack && state == ST_DEVADR && ack_ok &&
                    shift[0] == `I2CMP_RW_READ)
                    ack_drive <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ### verif/i2cmp_slave_props.sv
// pin checker of the slave port
// assumes a bind onto i2cmp_slave
`timescale 1ns/1ps
`default_nettype none
module i2cmp_slave_props (
    input wire logic CLK_I,
    input wire logic RESET_N_I,
    input wire logic SCL_I,
    input wire logic SDA_I,
    input wire logic SDA_O,
    input wire logic SDA_OE_O,
    input wire logic WRITE_PROTECT_I,
    input wire logic BUSY_O,
    input wire logic [12:0] ADDR_LATCH_O,
    input wire logic WRITE_BACKLOG_O
);
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (!RESET_N_I);
    a_low_only: assert property (
        SDA_OE_O |-> !SDA_O) else $error("sda driven high");
    a_oe_steady: assert property (
        $rose(SCL_I) |-> $stable(SDA_OE_O) [*5]) else $error("sda moved");
    a_idle_quiet: assert property (
        !BUSY_O |-> !SDA_OE_O) else $error("idle port drives sda");
    a_stop_idle: assert property (
        $rose(SDA_I) && SCL_I |-> ##[1:8] !BUSY_O) else $error("stop ignored");
    a_start_busy: assert property (
        $fell(SDA_I) && SCL_I |-> ##[1:8] BUSY_O) else $error("start ignored");
    a_wp_no_write: assert property (
        $past(WRITE_PROTECT_I, 4) |-> !$rose(WRITE_BACKLOG_O))
        else $error("protected write queued");
    a_write_drains: assert property (
        $rose(WRITE_BACKLOG_O) |-> ##[1:16] !WRITE_BACKLOG_O)
        else $error("write backlog stuck");
    a_latch_hold: assert property (
        !BUSY_O && !$past(BUSY_O) |-> $stable(ADDR_LATCH_O))
        else $error("latch moved while idle");
endmodule
bind i2cmp_slave i2cmp_slave_props i_i2cmp_slave_props (.CLK_I(CLK_I),
    .RESET_N_I(RESET_N_I), .SCL_I(SCL_I), .SDA_I(SDA_I), .SDA_O(SDA_O),
    .SDA_OE_O(SDA_OE_O), .WRITE_PROTECT_I(WRITE_PROTECT_I),
    .BUSY_O(BUSY_O), .ADDR_LATCH_O(ADDR_LATCH_O),
    .WRITE_BACKLOG_O(WRITE_BACKLOG_O));
`default_nettype wire

// ### verif/i2cmp_master_model.sv
// two-wire bus master model, scl still outside frames
// assumes a pull-up resolves the data line outside
`timescale 1ns/1ps
`default_nettype none
module i2cmp_master_model (
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_o
);
    initial scl_o = 1'b1;
    initial sda_o = 1'b1;
    task automatic clk_bit(input logic b, output logic s);
        scl_o <= 1'b0;
        #16 sda_o <= b;
        #16 scl_o <= 1'b1;
        #30 s = sda_i;
        #2;
    endtask
    task automatic start();
        scl_o <= 1'b0;
        #16 sda_o <= 1'b1;
        #16 scl_o <= 1'b1;
        #32 sda_o <= 1'b0;
        #32;
    endtask
    task automatic stop();
        scl_o <= 1'b0;
        #16 sda_o <= 1'b0;
        #16 scl_o <= 1'b1;
        #32 sda_o <= 1'b1;
        #32;
    endtask
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            clk_bit(d[i], s);
        clk_bit(1'b1, s);
        ack = !s;
    endtask
    task automatic rbyte(output logic [7:0] d, input logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            clk_bit(1'b1, d[i]);
        clk_bit(!ack, s);
    endtask
endmodule
`default_nettype wire

// ### verif/i2cmp_slave_tb_top.sv
// self-checking bench of the slave port
// assumes the master model and the bound checker
`timescale 1ns/1ps
`default_nettype none
`include "i2cmp_regs.vh"
module i2cmp_slave_tb_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [2:0] sel = 3'h0;
    logic wp = 1'b0;
    logic scl, m_sda, oe, sdo, busy, blog;
    logic [12:0] latch;
    logic [7:0] mem [0:8191];
    int n_mismatch = 0;
    int tests_run = 0;
    wire sda = m_sda & ~(oe & ~sdo);
    always #2.5 clk = ~clk;
    i2cmp_master_model i_i2cmp_master_model (.sda_i(sda), .scl_o(scl),
        .sda_o(m_sda));
    i2cmp_slave i_i2cmp_slave (.CLK_I(clk), .RESET_N_I(rst_n), .CE_I(1'b1),
        .SCL_I(scl), .SDA_I(sda), .SDA_O(sdo), .SDA_OE_O(oe),
        .DEVICE_SELECT_PINS_I(sel), .WRITE_PROTECT_I(wp), .BUSY_O(busy),
        .ADDR_LATCH_O(latch), .WRITE_BACKLOG_O(blog));
    task automatic stop_test();
        $display("tests_run=%0d n_mismatch=%0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    function automatic logic [7:0] id(input logic rd);
        return {`I2CMP_TYPE_CODE, sel, rd};
    endfunction
    task automatic put(input logic [7:0] d, input logic e);
        logic ack;
        i_i2cmp_master_model.wbyte(d, ack);
        chk(ack, e);
    endtask
    task automatic sla(input logic [7:0] b, input logic e);
        i_i2cmp_master_model.start();
        put(b, e);
    endtask
    task automatic set_addr(input logic [15:0] a);
        sla(id(0), 1);
        put(a[15:8], 1);
        put(a[7:0], 1);
    endtask
    task automatic wr(input logic [15:0] a, input int n);
        logic [7:0] d;
        set_addr(a);
        for (int i = 0; i < n; i++)
        begin
            d = 8'($urandom());
            put(d, !wp);
            if (!wp)
                mem[13'(a + i)] = d;
        end
        i_i2cmp_master_model.stop();
        chk(latch, wp ? a[12:0] : 13'(a + n));
    endtask
    task automatic rd(input logic [15:0] a, input int n, input logic cur);
        logic [7:0] d;
        if (!cur)
            set_addr(a);
        sla(id(1), 1);
        for (int i = 0; i < n; i++)
        begin
            i_i2cmp_master_model.rbyte(d, i < n - 1);
            chk(d, mem[13'(a + i)]);
        end
        i_i2cmp_master_model.stop();
        chk(busy, 0);
    endtask
    initial
    begin
        logic [15:0] a;
        int n;
        logic s;
        void'($urandom(43));
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        a = {3'($urandom()), 13'h1ffe};
        wr(a, 4);
        rd(a, 4, 0);
        $display("wrap test done");
        repeat (4)
        begin
            @(posedge clk);
            sel <= 3'($urandom());
            a = 16'($urandom());
            n = 1 + $urandom_range(3);
            @(posedge clk);
            wr(a, n);
            rd(a, n, 0);
        end
        $display("random test done");
        for (int i = 0; i < 7; i++)
        begin
            sla(id(0) ^ (8'h02 << i), 0);
            i_i2cmp_master_model.stop();
        end
        $display("address test done");
        @(posedge clk);
        wp <= 1'b1;
        @(posedge clk);
        wr(a, 2);
        @(posedge clk);
        wp <= 1'b0;
        @(posedge clk);
        rd(a, 1, 0);
        set_addr(a);
        for (int i = 0; i < 4; i++)
            i_i2cmp_master_model.clk_bit(~mem[a[12:0]][7 - i], s);
        i_i2cmp_master_model.stop();
        rd(a, 1, 1);
        $display("protect and abort test done");
        stop_test();
    end
    initial
    begin
        #400us;
        n_mismatch++;
        stop_test();
    end
endmodule
`default_nettype wire
